// ===== design/posr_ctl_if.sv
// Carries ramp settings from the register file to the ramp tick generator.
// Assumes one clock domain shared by both ends.
`default_nettype none
interface posr_ctl_if;
	logic                  ramp_en;
	posr_pkg::posr_slope_t slope;
	logic                  tick;
	modport ctl (output ramp_en, output slope, input tick);
	modport gen (input ramp_en, input slope, output tick);
endinterface
`default_nettype wire

// ===== design/posr_defines.svh
// Offsets, field positions, reset values and timing counts for the oscillator
// steering register block. Assumes it is included by bare name.
`ifndef POSR_DEFINES_SVH
`define POSR_DEFINES_SVH
// ==========================================================
// Register offsets within a page
`define POSR_OFF_RAMP     8'h30
`define POSR_OFF_FRAC0    8'h31
`define POSR_OFF_FRAC1    8'h32
`define POSR_OFF_FRAC2    8'h33
`define POSR_OFF_FRAC3    8'h34
`define POSR_OFF_STEER    8'h35
`define POSR_OFF_INT_LO   8'h36
`define POSR_OFF_INT_HI   8'h37
`define POSR_OFF_PAGE     8'hff
// Page that holds this block
`define POSR_HOME_PAGE    8'h00
`define POSR_RESET_VAL    8'h00
// ==========================================================
// Field positions
`define POSR_RAMP_SLOPE_HI 5
`define POSR_RAMP_SLOPE_LO 4
`define POSR_RAMP_EN_BIT   3
`define POSR_STEER_INC     3
`define POSR_STEER_DEC     2
`define POSR_STEER_FREE    1
`define POSR_STEER_MASK    0
`define POSR_SYNC_BIT      5
// ==========================================================
// Ramp step timing: one step of 0.2 ppm per step period.
// Slope codes step every 1 s, 100 ms, 10 ms, 1 ms at 0.2 ppm.
`define POSR_CLK_HZ        50000000
`define POSR_STEP_MS_S0    1000
`define POSR_STEP_MS_S1    100
`define POSR_STEP_MS_S2    10
`define POSR_STEP_MS_S3    1
`define POSR_TICK_PER_MS   (`POSR_CLK_HZ / 1000)
`endif

// ===== design/posr_pkg.sv
// Types shared by the oscillator steering register block.
// Assumes the defines header is compiled alongside.
`default_nettype none
package posr_pkg;
	// Slope codes for the frequency ramp
	typedef enum logic [1:0] {
		POSR_SLOPE_0P2 = 2'h0,
		POSR_SLOPE_2   = 2'h1,
		POSR_SLOPE_20  = 2'h2,
		POSR_SLOPE_200 = 2'h3
	} posr_slope_t;
	// Steering command states, one-hot
	typedef enum logic [2:0] {
		POSR_ST_IDLE = 3'h1,
		POSR_ST_INC  = 3'h2,
		POSR_ST_DEC  = 3'h4
	} posr_state_t;
endpackage
`default_nettype wire

// ===== design/posr_ramp_tick.sv
// Ramp step tick generator: one-cycle pulse at the rate set by the slope.
// Assumes a 50 MHz clock; counts held in flip-flops.
`default_nettype none
`include "posr_defines.svh"
module posr_ramp_tick (
	input  wire logic  i_clk,
	input  wire logic  i_resetn,
	posr_ctl_if.gen    ctl
);
	typedef struct packed {
		logic [15:0] ms_cnt;
		logic [9:0]  ms_num;
		logic        tick;
	} posr_tick_t;
	posr_tick_t st_r, st_nxt;
	localparam logic [15:0] MS_LAST = 16'(`POSR_TICK_PER_MS - 1);

	// Period in milliseconds for a slope code
	function automatic logic [9:0] posr_period(input posr_pkg::posr_slope_t s);
		case (s)
			posr_pkg::POSR_SLOPE_0P2: posr_period = 10'(`POSR_STEP_MS_S0);
			posr_pkg::POSR_SLOPE_2:   posr_period = 10'(`POSR_STEP_MS_S1);
			posr_pkg::POSR_SLOPE_20:  posr_period = 10'(`POSR_STEP_MS_S2);
			default:                  posr_period = 10'(`POSR_STEP_MS_S3);
		endcase
	endfunction

	// ==========================================================
	// Millisecond divider then per-slope step count
	always_comb begin
		st_nxt      = st_r;
		st_nxt.tick = 1'b0;
		if (!ctl.ramp_en) begin
			// Restart cleanly so the first step is a full period
			st_nxt.ms_cnt = 16'h0000;
			st_nxt.ms_num = 10'h000;
		end else if (st_r.ms_cnt == MS_LAST) begin
			st_nxt.ms_cnt = 16'h0000;
			if (st_r.ms_num + 10'h001 >= posr_period(ctl.slope)) begin
				st_nxt.ms_num = 10'h000;
				st_nxt.tick   = 1'b1;
			end else begin
				st_nxt.ms_num = st_r.ms_num + 10'h001;
			end
		end else begin
			st_nxt.ms_cnt = st_r.ms_cnt + 16'h0001;
		end
	end

	// State register
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign ctl.tick = st_r.tick;
endmodule
`default_nettype wire

// ===== design/posr_top.sv
// Oscillator steering register block for one PLL: paged 8-bit register map,
// ramp control, control codes, steering commands and page select.
// Assumes a synchronous 8-bit register port driven by an outside interface.
// Contract
// - Slope code 00..11 selects ramp 0.2, 2, 20 or 200 ppm/s.
// - Bit 3 of ramp register switches frequency ramp on, reset zero.
// - Three-bit divider field holds any value software writes.
// - Fraction code lives in four read/write bytes 31h to 34h.
// - Integer code is register 36h plus bits 7:6 of 37h.
// - Bit 3 of 35h steps frequency up by the programmed code.
// - Bit 2 of 35h steps frequency down by the programmed code.
// - Bit 1 of 35h enables oscillator free-run for this PLL.
// - Bit 0 of 35h masks oscillator steering for this PLL.
// - Bit 5 of 37h enables synchronized steering mode.
// - Every page has register FFh selecting the active page.
`default_nettype none
`include "posr_defines.svh"
module posr_top (
	// Clock and reset
	input  wire logic        I_CLOCK,
	input  wire logic        I_RESETN,
	// Register port
	input  wire logic        I_REG_WR,
	input  wire logic        I_REG_RD,
	input  wire logic [7:0]  I_REG_ADDR,
	input  wire logic [7:0]  I_REG_WDATA,
	output var  logic [7:0]  O_REG_RDATA,
	output var  logic        O_REG_RVALID,
	// Oscillator controls
	output var  logic [31:0] O_FRAC_CODE,
	output var  logic [9:0]  O_INT_CODE,
	output var  logic [2:0]  O_DIVIDER,
	output var  logic        O_STEP_UP,
	output var  logic        O_STEP_DOWN,
	output var  logic        O_FREE_RUN,
	output var  logic        O_STEER_MASK,
	output var  logic        O_SYNC_MODE,
	output var  logic        O_RAMP_ACTIVE,
	output var  logic [7:0]  O_PAGE
);
	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0]            ramp;
		logic [3:0][7:0]       frac;
		logic [7:0]            steer;
		logic [7:0]            int_lo;
		logic [7:0]            int_hi;
		logic [7:0]            page;
		logic [7:0]            rdata;
		logic                  rvalid;
		logic                  up;
		logic                  down;
		posr_pkg::posr_state_t fsm;
	} posr_state_t;
	posr_state_t st_r, st_nxt;

	posr_ctl_if ctl_if ();

	// Page decode used by read and write paths alike
	function automatic logic posr_here(input logic [7:0] pg, input logic [7:0] a);
		posr_here = (pg == `POSR_HOME_PAGE) && (a != `POSR_OFF_PAGE);
	endfunction

	// ==========================================================
	// Ramp tick generator
	posr_ramp_tick u_tick (
		.i_clk    (I_CLOCK),
		.i_resetn (I_RESETN),
		.ctl      (ctl_if.gen)
	);
	assign ctl_if.ramp_en = st_r.ramp[`POSR_RAMP_EN_BIT];
	assign ctl_if.slope   = posr_pkg::posr_slope_t'(
		st_r.ramp[`POSR_RAMP_SLOPE_HI:`POSR_RAMP_SLOPE_LO]);

	// ==========================================================
	// Register writes, reads and steering sequencer
	always_comb begin
		logic steer_ok;
		steer_ok       = 1'b0;
		st_nxt         = st_r;
		st_nxt.rvalid  = 1'b0;
		st_nxt.up      = 1'b0;
		st_nxt.down    = 1'b0;
		// Writes: every bit is plain storage, spare bits included
		if (I_REG_WR) begin
			if (I_REG_ADDR == `POSR_OFF_PAGE) begin
				st_nxt.page = I_REG_WDATA;
			end else if (posr_here(st_r.page, I_REG_ADDR)) begin
				case (I_REG_ADDR)
					`POSR_OFF_RAMP:   st_nxt.ramp    = I_REG_WDATA;
					`POSR_OFF_FRAC0:  st_nxt.frac[0] = I_REG_WDATA;
					`POSR_OFF_FRAC1:  st_nxt.frac[1] = I_REG_WDATA;
					`POSR_OFF_FRAC2:  st_nxt.frac[2] = I_REG_WDATA;
					`POSR_OFF_FRAC3:  st_nxt.frac[3] = I_REG_WDATA;
					`POSR_OFF_STEER:  st_nxt.steer   = I_REG_WDATA;
					`POSR_OFF_INT_LO: st_nxt.int_lo  = I_REG_WDATA;
					`POSR_OFF_INT_HI: st_nxt.int_hi  = I_REG_WDATA;
					default: ;
				endcase
			end
		end
		// Reads: one-cycle answer, unmapped addresses read zero
		if (I_REG_RD) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata  = 8'h00;
			if (I_REG_ADDR == `POSR_OFF_PAGE) begin
				st_nxt.rdata = st_r.page;
			end else if (posr_here(st_r.page, I_REG_ADDR)) begin
				case (I_REG_ADDR)
					`POSR_OFF_RAMP:   st_nxt.rdata = st_r.ramp;
					`POSR_OFF_FRAC0:  st_nxt.rdata = st_r.frac[0];
					`POSR_OFF_FRAC1:  st_nxt.rdata = st_r.frac[1];
					`POSR_OFF_FRAC2:  st_nxt.rdata = st_r.frac[2];
					`POSR_OFF_FRAC3:  st_nxt.rdata = st_r.frac[3];
					`POSR_OFF_STEER:  st_nxt.rdata = st_r.steer;
					`POSR_OFF_INT_LO: st_nxt.rdata = st_r.int_lo;
					`POSR_OFF_INT_HI: st_nxt.rdata = st_r.int_hi;
					default:          st_nxt.rdata = 8'h00;
				endcase
			end
		end
		// Steering: mask blocks all steps; a set command bit steps once from idle, up winning
		// over down, then again on each ramp tick while held and ramping. Software is
		// trusted to load the codes before setting a command bit.
		steer_ok = !st_r.steer[`POSR_STEER_MASK];
		case (st_r.fsm)
			posr_pkg::POSR_ST_IDLE: begin
				if (steer_ok && st_r.steer[`POSR_STEER_INC]) begin
					st_nxt.up  = 1'b1;
					st_nxt.fsm = posr_pkg::POSR_ST_INC;
				end else if (steer_ok && st_r.steer[`POSR_STEER_DEC]) begin
					st_nxt.down = 1'b1;
					st_nxt.fsm  = posr_pkg::POSR_ST_DEC;
				end
			end
			posr_pkg::POSR_ST_INC: begin
				if (!st_r.steer[`POSR_STEER_INC] || !steer_ok) begin
					st_nxt.fsm = posr_pkg::POSR_ST_IDLE;
				end else if (ctl_if.ramp_en && ctl_if.tick) begin
					st_nxt.up = 1'b1;
				end
			end
			posr_pkg::POSR_ST_DEC: begin
				if (!st_r.steer[`POSR_STEER_DEC] || !steer_ok) begin
					st_nxt.fsm = posr_pkg::POSR_ST_IDLE;
				end else if (ctl_if.ramp_en && ctl_if.tick) begin
					st_nxt.down = 1'b1;
				end
			end
			default: st_nxt.fsm = posr_pkg::POSR_ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			st_r     <= '0;
			st_r.fsm <= posr_pkg::POSR_ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs straight from state flip-flops
	assign O_REG_RDATA   = st_r.rdata;
	assign O_REG_RVALID  = st_r.rvalid;
	assign O_FRAC_CODE   = {st_r.frac[3], st_r.frac[2], st_r.frac[1], st_r.frac[0]};
	assign O_INT_CODE    = {st_r.int_hi[7:6], st_r.int_lo};
	assign O_DIVIDER     = st_r.ramp[2:0];
	assign O_STEP_UP     = st_r.up;
	assign O_STEP_DOWN   = st_r.down;
	assign O_FREE_RUN    = st_r.steer[`POSR_STEER_FREE];
	assign O_STEER_MASK  = st_r.steer[`POSR_STEER_MASK];
	assign O_SYNC_MODE   = st_r.int_hi[`POSR_SYNC_BIT];
	assign O_RAMP_ACTIVE = st_r.ramp[`POSR_RAMP_EN_BIT];
	assign O_PAGE        = st_r.page;
endmodule
`default_nettype wire

// ===== tb/posr_top_sva.sv
// Checker for the oscillator steering register block.
// Assumes it is bound to posr_top and sees only its ports.
`default_nettype none
module posr_top_sva (
	// Clock, reset, register port
	input wire logic        I_CLOCK,
	input wire logic        I_RESETN,
	input wire logic        I_REG_WR,
	input wire logic        I_REG_RD,
	input wire logic [7:0]  I_REG_ADDR,
	input wire logic [7:0]  I_REG_WDATA,
	// Watched outputs
	input wire logic        O_REG_RVALID,
	input wire logic [31:0] O_FRAC_CODE,
	input wire logic [9:0]  O_INT_CODE,
	input wire logic [2:0]  O_DIVIDER,
	input wire logic        O_STEP_UP,
	input wire logic        O_STEP_DOWN,
	input wire logic        O_FREE_RUN,
	input wire logic        O_STEER_MASK,
	input wire logic        O_SYNC_MODE,
	input wire logic        O_RAMP_ACTIVE,
	input wire logic [7:0]  O_PAGE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RESETN);
	// ==========================================================
	// Writes that land on the home page
	logic   wh;
	assign wh = I_REG_WR && O_PAGE == 8'h00;
	AST_FRAC: assert property (
		wh && I_REG_ADDR == 8'h34 |=> O_FRAC_CODE[31:24] == $past(I_REG_WDATA))
		else $error("fraction top byte not written");
	AST_INT: assert property (
		wh && I_REG_ADDR == 8'h37 |=> {O_INT_CODE[9:8], O_SYNC_MODE} == $past(I_REG_WDATA[7:5]))
		else $error("integer high or sync not written");
	AST_STEER: assert property (
		wh && I_REG_ADDR == 8'h35 |=> {O_FREE_RUN, O_STEER_MASK} == $past(I_REG_WDATA[1:0]))
		else $error("free run or mask not written");
	AST_RAMP: assert property (
		wh && I_REG_ADDR == 8'h30 |=> {O_RAMP_ACTIVE, O_DIVIDER} == $past(I_REG_WDATA[3:0]))
		else $error("ramp enable or divider not written");
	AST_PAGE: assert property (I_REG_WR && I_REG_ADDR == 8'hff |=> O_PAGE == $past(I_REG_WDATA))
		else $error("page select not written");
	// Off-page writes must leave the codes alone
	AST_REFUSE: assert property (
		I_REG_WR && O_PAGE != 8'h00 && I_REG_ADDR != 8'hff |=> $stable(O_FRAC_CODE) && $stable(O_INT_CODE))
		else $error("off-page write changed a code");
	AST_RVALID: assert property (I_REG_RD |=> O_REG_RVALID)
		else $error("read not answered");
	AST_PULSE: assert property (O_STEP_UP || O_STEP_DOWN |=> !O_STEP_UP && !O_STEP_DOWN)
		else $error("step pulse longer than one cycle");
	// Mask held over two cycles must block any step
	AST_MASK: assert property (O_STEER_MASK && $past(O_STEER_MASK) |-> !O_STEP_UP && !O_STEP_DOWN)
		else $error("step while masked");
	COV_UP: cover property (O_STEP_UP);
	COV_DN: cover property (O_STEP_DOWN);
	COV_OFF: cover property (O_REG_RVALID && O_PAGE != 8'h00);
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for posr_top: register rows, steering, paging, ramp.
// Assumes a 50 MHz clock and the design compiled alongside.
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        I_CLOCK, I_RESETN, I_REG_WR, I_REG_RD;
	logic [7:0]  I_REG_ADDR, I_REG_WDATA, O_REG_RDATA, O_PAGE, v;
	logic [31:0] O_FRAC_CODE;
	logic [9:0]  O_INT_CODE;
	logic [2:0]  O_DIVIDER;
	logic        O_REG_RVALID, O_STEP_UP, O_STEP_DOWN, O_FREE_RUN, O_STEER_MASK, O_SYNC_MODE, O_RAMP_ACTIVE;
	int          fail_count, n_tests, up_n, dn_n, up0, dn0, n;
	// Rows: address, write data (also the readback)
	logic [15:0] rows [7] = '{16'h3033, 16'h31a5, 16'h325a, 16'h33c3, 16'h343c, 16'h3696, 16'h37f5};
	posr_top u_dut (.I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN), .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD),
		.I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
		.O_REG_RVALID(O_REG_RVALID), .O_FRAC_CODE(O_FRAC_CODE), .O_INT_CODE(O_INT_CODE),
		.O_DIVIDER(O_DIVIDER), .O_STEP_UP(O_STEP_UP), .O_STEP_DOWN(O_STEP_DOWN), .O_FREE_RUN(O_FREE_RUN),
		.O_STEER_MASK(O_STEER_MASK), .O_SYNC_MODE(O_SYNC_MODE), .O_RAMP_ACTIVE(O_RAMP_ACTIVE), .O_PAGE(O_PAGE));
	// ==========================================================
	// Clock and step pulse counters
	initial begin
		I_CLOCK = 0;
		forever #10 I_CLOCK = ~I_CLOCK;
	end
	always @(posedge I_CLOCK) begin
		up_n += int'(O_STEP_UP);
		dn_n += int'(O_STEP_DOWN);
	end
	// Gap cycle after each strobe so it is never set twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		I_REG_WR = 1;
		I_REG_ADDR = a;
		I_REG_WDATA = d;
		@(posedge I_CLOCK) #1;
		I_REG_WR = 0;
		@(posedge I_CLOCK) #1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		I_REG_RD = 1;
		I_REG_ADDR = a;
		@(posedge I_CLOCK) #1;
		I_REG_RD = 0;
		`CHK("rvalid", 1'b1, O_REG_RVALID)
		d = O_REG_RDATA;
		@(posedge I_CLOCK) #1;
	endtask
	// Clear the command bits first so each write is a fresh request
	task automatic st(input logic [7:0] d, input int eu, input int ed);
		wr(8'h35, 8'h00);
		up0 = up_n;
		dn0 = dn_n;
		wr(8'h35, d);
		repeat (8) @(posedge I_CLOCK);
		#1;
		`CHK("steps up", eu, up_n - up0)
		`CHK("steps down", ed, dn_n - dn0)
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Tests need about 50,100 cycles, mostly the 1 ms ramp wait; 70,000 leaves margin
	initial begin
		#1400000;
		fail_count++;
		summarize();
	end
	// ==========================================================
	// Main sequence
	initial begin
		{I_RESETN, I_REG_WR, I_REG_RD, I_REG_ADDR, I_REG_WDATA} = '0;
		repeat (2) @(posedge I_CLOCK);
		#1 I_RESETN = 1;
		`CHK("codes at reset", 50'h0, {O_FRAC_CODE, O_INT_CODE, O_PAGE})
		`CHK("strobes at reset", 6'h0, {O_DIVIDER, O_REG_RVALID, O_STEP_UP, O_STEP_DOWN})
		`CHK("modes at reset", 4'h0, {O_FREE_RUN, O_STEER_MASK, O_SYNC_MODE, O_RAMP_ACTIVE})
		foreach (rows[i]) begin
			rd(rows[i][15:8], v);
			`CHK("reset value", 8'h00, v)
			wr(rows[i][15:8], rows[i][7:0]);
			rd(rows[i][15:8], v);
			`CHK("readback", rows[i][7:0], v)
		end
		`CHK("frac code", 32'h3cc35aa5, O_FRAC_CODE)
		`CHK("int code", 10'h396, O_INT_CODE)
		`CHK("sync", 1'b1, O_SYNC_MODE)
		`CHK("divider", 3'h3, O_DIVIDER)
		`CHK("ramp off", 1'b0, O_RAMP_ACTIVE)
		// Codes were loaded by the rows above, before any command bit is set
		st(8'h08, 1, 0);
		st(8'h04, 0, 1);
		st(8'h0c, 1, 0);
		st(8'h09, 0, 0);
		`CHK("mask", 1'b1, O_STEER_MASK)
		st(8'hf6, 0, 1);
		`CHK("free run", 1'b1, O_FREE_RUN)
		// Off-page and unmapped accesses
		wr(8'hff, 8'h01);
		wr(8'h31, 8'hff);
		rd(8'h31, v);
		`CHK("off page read", 8'h00, v)
		rd(8'hff, v);
		`CHK("page", 8'h01, v)
		wr(8'hff, 8'h00);
		wr(8'h40, 8'h77);
		rd(8'h40, v);
		`CHK("unmapped", 8'h00, v)
		`CHK("frac kept", 32'h3cc35aa5, O_FRAC_CODE)
		// Fastest slope repeats a step every 1 ms
		wr(8'h35, 8'h00);
		wr(8'h30, 8'h38);
		wr(8'h35, 8'h08);
		up0 = up_n;
		for (n = 0; n < 60000 && up_n < up0 + 2; n++)
			@(posedge I_CLOCK);
		// Step off the edge before driving again
		#1;
		`CHK("ramp period", 1'b1, n > 49900 && n < 50100)
		wr(8'h30, 8'h00);
		I_RESETN = 0;
		@(posedge I_CLOCK) #1 I_RESETN = 1;
		`CHK("frac after reset", 32'h0, O_FRAC_CODE)
		summarize();
	end
endmodule
bind posr_top posr_top_sva u_sva (.I_CLOCK(I_CLOCK), .I_RESETN(I_RESETN), .I_REG_WR(I_REG_WR),
	.I_REG_RD(I_REG_RD), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .O_REG_RVALID(O_REG_RVALID),
	.O_FRAC_CODE(O_FRAC_CODE), .O_INT_CODE(O_INT_CODE), .O_DIVIDER(O_DIVIDER), .O_STEP_UP(O_STEP_UP),
	.O_STEP_DOWN(O_STEP_DOWN), .O_FREE_RUN(O_FREE_RUN), .O_STEER_MASK(O_STEER_MASK),
	.O_SYNC_MODE(O_SYNC_MODE), .O_RAMP_ACTIVE(O_RAMP_ACTIVE), .O_PAGE(O_PAGE));
`default_nettype wire
